// ===== pkg/lts_pkg.sv
/*
  lts_pkg: shared constants, types and register map of the limit and
  time switch block.
  assumes: one clock at 25 MHz, software access over APB.
*/
`default_nettype none
package lts_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned SEC_NS        = 1000000000;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TICK_CYC      = SEC_NS / CLK_PERIOD_NS;
  localparam logic [16:0] SEC_PER_DAY   = 17'h15180;
  localparam logic [5:0]  SEC_PER_MIN   = 6'h3c;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_LIMIT      = 8'h04;
  localparam logic [7:0] OFS_RANGE_LO   = 8'h08;
  localparam logic [7:0] OFS_RANGE_HI   = 8'h0c;
  localparam logic [7:0] OFS_HYST       = 8'h10;
  localparam logic [7:0] OFS_DELAY      = 8'h14;
  localparam logic [7:0] OFS_DELTA_VAL  = 8'h18;
  localparam logic [7:0] OFS_DELTA_TIME = 8'h1c;
  localparam logic [7:0] OFS_AUTO_CONF  = 8'h20;
  localparam logic [7:0] OFS_STATUS     = 8'h24;
  localparam logic [7:0] OFS_INT_STAT   = 8'h28;
  localparam logic [7:0] OFS_INT_MASK   = 8'h2c;
  localparam logic [7:0] OFS_CAL_DAY    = 8'h30;
  localparam logic [7:0] OFS_CAL_SEC    = 8'h34;
  localparam logic [7:0] OFS_TS_DAY     = 8'h38;
  localparam logic [7:0] OFS_TS_SEC     = 8'h3c;
  localparam logic [7:0] OFS_TS_DUR     = 8'h40;
  localparam logic [7:0] OFS_TS_PERIOD  = 8'h44;
  localparam logic [7:0] OFS_NEXT_DAY   = 8'h48;
  localparam logic [7:0] OFS_NEXT_SEC   = 8'h4c;
  localparam logic [7:0] OFS_MV         = 8'h50;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_LS_EN  = 0;
  localparam int CTRL_MODE_L = 1;
  localparam int CTRL_TS_EN  = 4;
  localparam int IRQ_LS      = 0;
  localparam int IRQ_RATE    = 1;
  localparam int IRQ_TS      = 2;
  localparam logic [16:0] RST_DELTA_TIME = 17'h00e10;
  localparam logic [10:0] RST_AUTO_CONF  = 11'h001;
  localparam logic [23:0] RST_TS_TIME    = 24'h000003;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_ABOVE   = 3'h0,
    MODE_BELOW   = 3'h1,
    MODE_INSIDE  = 3'h2,
    MODE_OUTSIDE = 3'h3,
    MODE_RATE    = 3'h4
  } lts_mode_t;

  typedef enum logic [1:0] {
    SW_OFF = 2'b01,
    SW_ON  = 2'b10
  } lts_sw_t;

  typedef struct packed {
    logic [15:0] day;
    logic [16:0] sod;
  } lts_cal_t;

  typedef struct packed {
    logic        en;
    lts_cal_t    start;
    logic [23:0] dur;
    logic [23:0] period;
  } lts_ts_cfg_t;

endpackage
`default_nettype wire

// ===== design/lts_tswitch.sv
/*
  lts_tswitch: periodic calendar time switch.
  assumes: tick_in is a one-cycle pulse once a second, now_in is the
  calendar time that advances on that tick.
*/
`timescale 1ns/1ns
`default_nettype none
module lts_tswitch
(
  // clock and reset
  input  wire logic            clk_in,
  input  wire logic            rst_n_in,
  // time base
  input  wire logic            tick_in,
  input  wire lts_pkg::lts_cal_t    now_in,
  input  wire lts_pkg::lts_ts_cfg_t cfg_in,
  // results
  output logic                 signal_out,
  output logic                 rise_out,
  output lts_pkg::lts_cal_t    next_out
);
  import lts_pkg::*;

  logic [15:0] nday;
  logic [23:0] nsod;
  logic [23:0] rem;
  logic        pending;
  logic        due;

  // next rise is normalised before compare
  assign pending = nsod >= {7'h00, SEC_PER_DAY};
  assign due = !pending && ((now_in.day > nday) ||
               ((now_in.day == nday) && ({7'h00, now_in.sod} >= nsod)));
  assign next_out.day = nday;
  assign next_out.sod = nsod[16:0];

  // ---------------------------------------------------------------
  // cycle control
  // ---------------------------------------------------------------
  // disabled: idle low, next rise parked on the start time
  always_ff @(posedge clk_in)
  begin
    rise_out <= 1'b0;
    if (!rst_n_in || !cfg_in.en)
    begin
      nday       <= cfg_in.start.day;
      nsod       <= {7'h00, cfg_in.start.sod};
      signal_out <= 1'b0;
      rem        <= 24'h000000;
    end
    else if (pending)
    begin
      // one day per clock; at most 194 clocks
      nsod <= nsod - {7'h00, SEC_PER_DAY};
      nday <= nday + 16'h0001;
    end
    else if (tick_in && due)
    begin
      signal_out <= 1'b1;
      rise_out   <= 1'b1;
      rem        <= cfg_in.dur;
      nsod       <= nsod + cfg_in.period;
    end
    else if (tick_in && signal_out)
    begin
      if (rem <= 24'h000001)
      begin
        signal_out <= 1'b0;
        rem        <= 24'h000000;
      end
      else
        rem <= rem - 24'h000001;
    end
  end

endmodule
`default_nettype wire

// ===== design/lts_top.sv
/*
  lts_top: process-value monitor with one limit switch and one time
  switch, registers over APB.
  assumes: measured values arrive synchronous to clk_in with a valid
  strobe; software sets the calendar after reset.
*/
// Functional notes
// - Above-limit: output on after value exceeds limit+hyst for the start delay.
// - Above-limit: output off after value falls below limit-hyst for the off delay.
// - Range: output on once value exceeds lower bound+hyst and stays below upper bound-hyst for the start delay.
// - Range: output off once value falls below lower bound-hyst or exceeds upper bound+hyst for the off delay.
// - Rate mode raises an event when the value moves more than delta within the window.
// - No further rate event while the alarm status stays set.
// - Rate alarm clears once the slope stays low for the auto-confirm time.
// - Time switch has an enable that is off after reset.
// - Time switch first cycle starts at the configured start date and time.
// - Time switch output is high for the duration at the start of each period.
// - Time switch output is a single level readable by software.
// - Next rise date and time are read-only values.
// - Five monitoring modes, above-limit after reset.
// - Limit switch has an enable that is off after reset.
`timescale 1ns/1ns
`default_nettype none
module lts_top
#(
  parameter int unsigned TICK_CYCLES = lts_pkg::TICK_CYC
)
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // apb slave
  input  wire logic [7:0]  paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // measurement channel
  input  wire logic        mv_valid_in,
  input  wire logic [15:0] measured_value_in,
  // switch results
  output logic             ls_out,
  output logic             ls_event_out,
  output logic             ts_signal_out,
  output logic             irq_out
);
  import lts_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // sign extension so limit +/- hysteresis cannot overflow
  function automatic logic signed [17:0] sx(input logic [15:0] v);
    sx = {{2{v[15]}}, v};
  endfunction

  // magnitude of a difference of two measured values
  function automatic logic [17:0] absdiff(input logic [15:0] a,
                                          input logic [15:0] b);
    logic signed [17:0] d;
    d = sx(a) - sx(b);
    absdiff = d[17] ? 18'(-d) : 18'(d);
  endfunction

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic        ls_en;
  lts_mode_t   mode;
  logic [15:0] limit;
  logic [15:0] range_lo;
  logic [15:0] range_hi;
  logic [15:0] hyst;
  logic [15:0] on_dly;
  logic [15:0] off_dly;
  logic [15:0] delta_val;
  logic [16:0] delta_time;
  logic [10:0] auto_conf;
  logic [2:0]  int_stat;
  logic [2:0]  int_mask;
  logic [15:0] mv;
  lts_ts_cfg_t ts_cfg;
  lts_cal_t    now;
  lts_cal_t    ts_next;
  logic        ts_rise;

  logic [31:0] tick_cnt;
  logic        tick;
  logic        wr;
  logic        setup;
  logic [31:0] next_rdata;
  logic        next_err;

  logic        on_c;
  logic        off_c;
  lts_sw_t     sw_st;
  logic [15:0] dly_cnt;
  logic        ls_rise;

  logic [15:0] ref_mv;
  logic [16:0] win_cnt;
  logic [16:0] ac_cnt;
  logic [16:0] ac_lim;
  logic        rate_alarm;
  logic        rate_evt;
  logic        exceed;
  logic        rate_on;

  // ---------------------------------------------------------------
  // second tick and calendar
  // ---------------------------------------------------------------
  // prescaler for the common one-second tick
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || tick)
      tick_cnt <= 32'h00000000;
    else
      tick_cnt <= tick_cnt + 32'h00000001;
  end
  assign tick = tick_cnt == 32'(TICK_CYCLES - 1);

  // calendar: day number since the first day of 2000, second of day
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      now <= '0;
    else if (wr && paddr_in == OFS_CAL_DAY)
      now.day <= pwdata_in[15:0];
    else if (wr && paddr_in == OFS_CAL_SEC)
      now.sod <= pwdata_in[16:0];
    else if (tick)
    begin
      if (now.sod >= SEC_PER_DAY - 17'h00001)
      begin
        now.sod <= 17'h00000;
        now.day <= now.day + 16'h0001;
      end
      else
        now.sod <= now.sod + 17'h00001;
    end
  end

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  // zero wait states; read data is taken in the setup phase
  assign pready_out = 1'b1;
  assign setup      = psel_in && !penable_in;
  assign wr         = psel_in && penable_in && pwrite_in;

  // configuration registers
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      ls_en      <= 1'b0;
      mode       <= MODE_ABOVE;
      limit      <= 16'h0000;
      range_lo   <= 16'h0000;
      range_hi   <= 16'h0000;
      hyst       <= 16'h0000;
      on_dly     <= 16'h0000;
      off_dly    <= 16'h0000;
      delta_val  <= 16'h0000;
      delta_time <= RST_DELTA_TIME;
      auto_conf  <= RST_AUTO_CONF;
      ts_cfg     <= '0;
      ts_cfg.dur    <= RST_TS_TIME;
      ts_cfg.period <= RST_TS_TIME;
    end
    else if (wr)
    begin
      unique case (paddr_in)
        OFS_CTRL:
        begin
          ls_en     <= pwdata_in[CTRL_LS_EN];
          mode      <= lts_mode_t'(pwdata_in[CTRL_MODE_L +: 3]);
          ts_cfg.en <= pwdata_in[CTRL_TS_EN];
        end
        OFS_LIMIT:      limit      <= pwdata_in[15:0];
        OFS_RANGE_LO:   range_lo   <= pwdata_in[15:0];
        OFS_RANGE_HI:   range_hi   <= pwdata_in[15:0];
        OFS_HYST:       hyst       <= pwdata_in[15:0];
        OFS_DELAY:
        begin
          on_dly  <= pwdata_in[15:0];
          off_dly <= pwdata_in[31:16];
        end
        OFS_DELTA_VAL:  delta_val  <= pwdata_in[15:0];
        OFS_DELTA_TIME: delta_time <= pwdata_in[16:0];
        OFS_AUTO_CONF:  auto_conf  <= pwdata_in[10:0];
        OFS_TS_DAY:     ts_cfg.start.day <= pwdata_in[15:0];
        OFS_TS_SEC:     ts_cfg.start.sod <= pwdata_in[16:0];
        OFS_TS_DUR:     ts_cfg.dur       <= pwdata_in[23:0];
        OFS_TS_PERIOD:  ts_cfg.period    <= pwdata_in[23:0];
        default:        ;
      endcase
    end
  end

  // read mux and unmapped-address error, both registered
  always_comb
  begin
    next_rdata = 32'h00000000;
    next_err   = 1'b0;
    unique case (paddr_in)
      OFS_CTRL:       next_rdata = {27'h0, ts_cfg.en, mode, ls_en};
      OFS_LIMIT:      next_rdata = {16'h0, limit};
      OFS_RANGE_LO:   next_rdata = {16'h0, range_lo};
      OFS_RANGE_HI:   next_rdata = {16'h0, range_hi};
      OFS_HYST:       next_rdata = {16'h0, hyst};
      OFS_DELAY:      next_rdata = {off_dly, on_dly};
      OFS_DELTA_VAL:  next_rdata = {16'h0, delta_val};
      OFS_DELTA_TIME: next_rdata = {15'h0, delta_time};
      OFS_AUTO_CONF:  next_rdata = {21'h0, auto_conf};
      OFS_STATUS:     next_rdata = {29'h0, ts_signal_out, rate_alarm,
                                    ls_out};
      OFS_INT_STAT:   next_rdata = {29'h0, int_stat};
      OFS_INT_MASK:   next_rdata = {29'h0, int_mask};
      OFS_CAL_DAY:    next_rdata = {16'h0, now.day};
      OFS_CAL_SEC:    next_rdata = {15'h0, now.sod};
      OFS_TS_DAY:     next_rdata = {16'h0, ts_cfg.start.day};
      OFS_TS_SEC:     next_rdata = {15'h0, ts_cfg.start.sod};
      OFS_TS_DUR:     next_rdata = {8'h0, ts_cfg.dur};
      OFS_TS_PERIOD:  next_rdata = {8'h0, ts_cfg.period};
      OFS_NEXT_DAY:   next_rdata = {16'h0, ts_next.day};
      OFS_NEXT_SEC:   next_rdata = {15'h0, ts_next.sod};
      OFS_MV:         next_rdata = {16'h0, mv};
      default:        next_err   = 1'b1;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      prdata_out  <= 32'h00000000;
      pslverr_out <= 1'b0;
    end
    else if (setup)
    begin
      prdata_out  <= pwrite_in ? 32'h00000000 : next_rdata;
      pslverr_out <= next_err;
    end
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  // sticky status, write one to clear; a new event wins over clear
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      int_stat <= 3'h0;
      int_mask <= 3'h0;
    end
    else
    begin
      if (wr && paddr_in == OFS_INT_MASK)
        int_mask <= pwdata_in[2:0];
      int_stat <= (int_stat & ~((wr && paddr_in == OFS_INT_STAT) ?
                   pwdata_in[2:0] : 3'h0))
                  | {ts_rise, rate_evt, ls_rise};
    end
  end
  assign irq_out = |(int_stat & int_mask);

  // latest measured value
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      mv <= 16'h0000;
    else if (mv_valid_in)
      mv <= measured_value_in;
  end

  // ---------------------------------------------------------------
  // limit switch
  // ---------------------------------------------------------------
  // switch-on and switch-off conditions per mode, hysteresis applied
  always_comb
  begin
    on_c  = 1'b0;
    off_c = 1'b0;
    unique case (mode)
      MODE_ABOVE:
      begin
        on_c  = sx(mv) > sx(limit) + sx(hyst);
        off_c = sx(mv) < sx(limit) - sx(hyst);
      end
      MODE_BELOW:
      begin
        on_c  = sx(mv) < sx(limit) - sx(hyst);
        off_c = sx(mv) > sx(limit) + sx(hyst);
      end
      MODE_INSIDE:
      begin
        on_c  = (sx(mv) > sx(range_lo) + sx(hyst)) &&
                (sx(mv) < sx(range_hi) - sx(hyst));
        off_c = (sx(mv) < sx(range_lo) - sx(hyst)) ||
                (sx(mv) > sx(range_hi) + sx(hyst));
      end
      MODE_OUTSIDE:
      begin
        on_c  = (sx(mv) < sx(range_lo) - sx(hyst)) ||
                (sx(mv) > sx(range_hi) + sx(hyst));
        off_c = (sx(mv) > sx(range_lo) + sx(hyst)) &&
                (sx(mv) < sx(range_hi) - sx(hyst));
      end
      default: ;
    endcase
  end

  // delayed switching: a condition must hold for whole seconds
  always_ff @(posedge clk_in)
  begin
    ls_rise <= 1'b0;
    if (!rst_n_in || !ls_en || mode == MODE_RATE)
    begin
      sw_st   <= SW_OFF;
      dly_cnt <= 16'h0000;
    end
    else
    begin
      unique case (sw_st)
        SW_OFF:
          if (!on_c)
            dly_cnt <= 16'h0000;
          else if (dly_cnt >= on_dly)
          begin
            sw_st   <= SW_ON;
            ls_rise <= 1'b1;
            dly_cnt <= 16'h0000;
          end
          else if (tick)
            dly_cnt <= dly_cnt + 16'h0001;
        SW_ON:
          if (!off_c)
            dly_cnt <= 16'h0000;
          else if (dly_cnt >= off_dly)
          begin
            sw_st   <= SW_OFF;
            dly_cnt <= 16'h0000;
          end
          else if (tick)
            dly_cnt <= dly_cnt + 16'h0001;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // rate of change
  // ---------------------------------------------------------------
  assign rate_on = ls_en && mode == MODE_RATE;
  assign exceed  = absdiff(mv, ref_mv) > {2'h0, delta_val};
  assign ac_lim  = 17'(auto_conf) * 17'(SEC_PER_MIN);

  // window restarts from the current value at its end or an event
  always_ff @(posedge clk_in)
  begin
    rate_evt <= 1'b0;
    if (!rst_n_in || !rate_on)
    begin
      ref_mv     <= mv;
      win_cnt    <= 17'h00000;
      ac_cnt     <= 17'h00000;
      rate_alarm <= 1'b0;
    end
    else if (exceed)
    begin
      ref_mv     <= mv;
      win_cnt    <= 17'h00000;
      ac_cnt     <= 17'h00000;
      rate_alarm <= 1'b1;
      rate_evt   <= !rate_alarm;
    end
    else if (tick)
    begin
      if (win_cnt + 17'h00001 >= delta_time)
      begin
        ref_mv  <= mv;
        win_cnt <= 17'h00000;
      end
      else
        win_cnt <= win_cnt + 17'h00001;
      if (rate_alarm)
      begin
        if (ac_cnt + 17'h00001 >= ac_lim)
        begin
          rate_alarm <= 1'b0;
          ac_cnt     <= 17'h00000;
        end
        else
          ac_cnt <= ac_cnt + 17'h00001;
      end
    end
  end

  // switch outputs
  assign ls_out       = (sw_st == SW_ON) || rate_alarm;
  assign ls_event_out = rate_evt;

  // ---------------------------------------------------------------
  // time switch
  // ---------------------------------------------------------------
  lts_tswitch u_tswitch
  (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .tick_in    (tick),
    .now_in     (now),
    .cfg_in     (ts_cfg),
    .signal_out (ts_signal_out),
    .rise_out   (ts_rise),
    .next_out   (ts_next)
  );

endmodule
`default_nettype wire

// ===== tb/lts_top_asserts.sv
/*
  lts_top_asserts: port checker for lts_top.
  assumes: bound to lts_top, sync active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module lts_top_asserts
(
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  // apb slave
  input wire logic [7:0]  paddr_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // results
  input wire logic        ls_out,
  input wire logic        ls_event_out,
  input wire logic        ts_signal_out
);
  import lts_pkg::*;
  logic [4:0] ctrl_q;
  logic [4:0] ctrl_d1;
  logic       rate_q;
  logic       rate_d1;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ---------------------------------------------------------------
  // control word mirror
  // ---------------------------------------------------------------
  // mirror of ctrl writes, plus a copy one cycle old
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_q  <= 5'h00;
      ctrl_d1 <= 5'h00;
    end
    else
    begin
      if (psel_in && penable_in && pwrite_in && paddr_in == OFS_CTRL)
        ctrl_q <= pwdata_in[4:0];
      ctrl_d1 <= ctrl_q;
    end
  end
  // rate mode on
  assign rate_q  = ctrl_q[0] && ctrl_q[3:1] == 3'h4;
  assign rate_d1 = ctrl_d1[0] && ctrl_d1[3:1] == 3'h4;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_ls_off;
    !ctrl_q[0] && !ctrl_d1[0] |-> !ls_out;
  endproperty
  a_ls_off: assert property (p_ls_off) else $error("limit out while off");
  property p_ts_off;
    !ctrl_q[4] && !ctrl_d1[4] |-> !ts_signal_out;
  endproperty
  a_ts_off: assert property (p_ts_off) else $error("time out while off");
  property p_ev_mode;
    ls_event_out |-> rate_d1;
  endproperty
  a_ev_mode: assert property (p_ev_mode) else $error("event outside rate");
  property p_ev_pulse;
    ls_event_out |=> !ls_event_out;
  endproperty
  a_ev_pulse: assert property (p_ev_pulse) else $error("event too long");
  property p_ev_alarm;
    ls_event_out |-> ##[0:1] ls_out;
  endproperty
  a_ev_alarm: assert property (p_ev_alarm) else $error("event, no alarm");
  property p_no_rearm;
    ls_out && $past(ls_out) && rate_q && rate_d1 |-> !ls_event_out;
  endproperty
  a_no_rearm: assert property (p_no_rearm) else $error("event in alarm");
  property p_ts_width;
    $rose(ts_signal_out) |=> ts_signal_out [*8];
  endproperty
  a_ts_width: assert property (p_ts_width) else $error("pulse too short");
  property p_ready;
    psel_in && penable_in |-> pready_out;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_unmapped;
    psel_in && !penable_in && paddr_in > OFS_MV |=> pslverr_out;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no slverr");
endmodule
bind lts_top lts_top_asserts u_chk (.*);
`default_nettype wire

// ===== tb/lts_mv_model.sv
/*
  lts_mv_model: measurement channel feeding lts_top.
  assumes: bench sets value and sample spacing.
*/
`timescale 1ns/1ns
`default_nettype none
module lts_mv_model
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // bench side
  input  wire logic [15:0] value_in,
  input  wire logic [3:0]  pace_in,
  // channel side
  output logic             mv_valid_out,
  output logic [15:0]      measured_value_out
);
  logic [3:0]  gap;
  logic [15:0] last;
  // one sample every pace_in+1 cycles
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      gap          <= 4'h0;
      last         <= 16'h0000;
      mv_valid_out <= 1'b0;
    end
    else if (gap >= pace_in)
    begin
      gap          <= 4'h0;
      last         <= value_in;
      mv_valid_out <= 1'b1;
    end
    else
    begin
      gap          <= gap + 4'h1;
      mv_valid_out <= 1'b0;
    end
  end
  // stale data shows inverted
  assign measured_value_out = mv_valid_out ? last : ~last;
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
/*
  tb_top: self-checking bench for lts_top.
  assumes: second shortened to 10 cycles through TICK_CYCLES.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import lts_pkg::*;
  logic        clk_in, rst_n_in, psel_in, penable_in, pwrite_in;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic        pready_out, pslverr_out, mv_valid_in, er;
  logic [15:0] measured_value_in, mv_set;
  logic        ls_out, ls_event_out, ts_signal_out, irq_out;
  logic [3:0]  pace;
  int          failures, num_checks, ev_count, n0, n;
  logic [7:0]  rst_a [5] = '{OFS_CTRL, OFS_DELTA_TIME, OFS_AUTO_CONF,
                             OFS_TS_DUR, OFS_TS_PERIOD};
  logic [31:0] rst_v [5] = '{32'h0, 32'he10, 32'h1, 32'h3, 32'h3};
  // per mode: rest, band off, on, band on
  logic [15:0] tab [4][4] = '{'{16'h50, 16'h69, 16'h78, 16'h5f},
    '{16'h78, 16'h5f, 16'h50, 16'h69}, '{16'hfa, 16'hcd, 16'h64, 16'hc3},
    '{16'h64, 16'hcd, 16'hfa, 16'hc3}};
  lts_top #(.TICK_CYCLES(10)) DUT (.*);
  lts_mv_model u_mv (.clk_in, .rst_n_in, .value_in(mv_set),
    .pace_in(pace), .mv_valid_out(mv_valid_in),
    .measured_value_out(measured_value_in));
  // ---------------------------------------------------------------
  // clock and event counter
  // ---------------------------------------------------------------
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // counts rate events
  always @(posedge clk_in)
    if (ls_event_out === 1'b1) ev_count++;
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task final_report;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task check_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task wait_cyc(input int c);
    repeat (c) @(posedge clk_in);
  endtask
  // one apb transfer, held until ready is sampled
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int i;
    @(posedge clk_in);
    psel_in <= 1'b1;
    paddr_in <= a;
    pwrite_in <= w;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk_in);
      i++;
    end
    while (pready_out !== 1'b1 && i < 50);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (i >= 50)
    begin
      failures++;
      final_report();
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    check_word(rd, exp);
  endtask
  // wait for time switch level lvl
  task wait_ts(input logic lvl);
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (ts_signal_out !== lvl && n < 200);
    if (n >= 200)
    begin
      failures++;
      final_report();
    end
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {rst_n_in, psel_in, penable_in, pwrite_in} = 4'h0;
    {paddr_in, pwdata_in, mv_set, pace} = '0;
    {failures, num_checks, ev_count} = '0;
    wait_cyc(20);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 5; i++)
      rdchk(rst_a[i], rst_v[i]);
    apb(8'h54, 1'b0, 32'h0);
    check_word({rd[30:0], er}, 32'h1);
    // limit modes, start delay 2 s, off delay 3 s
    pace <= 4'h3;
    wr(OFS_LIMIT, 32'h64);
    wr(OFS_RANGE_HI, 32'hc8);
    wr(OFS_HYST, 32'ha);
    wr(OFS_DELAY, 32'h00030002);
    for (int m = 0; m < 4; m++)
    begin
      mv_set <= tab[m][0];
      wr(OFS_CTRL, 32'(m * 2 + 1));
      wait_cyc(50);
      check_word({31'h0, ls_out}, 32'h0);
      mv_set <= tab[m][1];
      wait_cyc(50);
      check_word({31'h0, ls_out}, 32'h0);
      mv_set <= tab[m][2];
      wait_cyc(5);
      check_word({31'h0, ls_out}, 32'h0);
      wait_cyc(30);
      check_word({31'h0, ls_out}, 32'h1);
      mv_set <= tab[m][3];
      wait_cyc(50);
      check_word({31'h0, ls_out}, 32'h1);
      mv_set <= tab[m][0];
      wait_cyc(15);
      check_word({31'h0, ls_out}, 32'h1);
      wait_cyc(30);
      check_word({31'h0, ls_out}, 32'h0);
      wr(OFS_CTRL, 32'h0);
    end
    wr(OFS_INT_MASK, 32'h1);
    wait_cyc(1);
    check_word({31'h0, irq_out}, 32'h1);
    wr(OFS_INT_STAT, 32'h1);
    wait_cyc(1);
    check_word({31'h0, irq_out}, 32'h0);
    // rate mode, delta 50, window 5 s, confirm 1 min
    pace <= 4'h0;
    mv_set <= 16'h0;
    wr(OFS_DELTA_VAL, 32'h32);
    wr(OFS_DELTA_TIME, 32'h5);
    wr(OFS_CTRL, 32'h9);
    wait_cyc(80);
    n0 = ev_count;
    mv_set <= 16'h64;
    wait_cyc(10);
    check_word(32'(ev_count - n0), 32'h1);
    check_word({31'h0, ls_out}, 32'h1);
    mv_set <= 16'hc8;
    wait_cyc(100);
    check_word(32'(ev_count - n0), 32'h1);
    wait_cyc(400);
    check_word({31'h0, ls_out}, 32'h1);
    wait_cyc(400);
    check_word({31'h0, ls_out}, 32'h0);
    mv_set <= 16'h0;
    wait_cyc(10);
    check_word(32'(ev_count - n0), 32'h2);
    rdchk(OFS_INT_STAT, 32'h2);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_INT_STAT, 32'h7);
    // time switch: start day 5 second 110, 3 s on in 5 s
    wr(OFS_CAL_DAY, 32'h5);
    wr(OFS_CAL_SEC, 32'h64);
    wr(OFS_TS_DAY, 32'h5);
    wr(OFS_TS_SEC, 32'h6e);
    wr(OFS_TS_PERIOD, 32'h5);
    rdchk(OFS_NEXT_DAY, 32'h5);
    wr(OFS_NEXT_SEC, 32'h0);
    rdchk(OFS_NEXT_SEC, 32'h6e);
    wr(OFS_CTRL, 32'h10);
    wait_cyc(60);
    check_word({31'h0, ts_signal_out}, 32'h0);
    wait_ts(1'b1);
    wait_ts(1'b0);
    check_word(32'(n), 32'h1e);
    wait_ts(1'b1);
    check_word(32'(n), 32'h14);
    rdchk(OFS_STATUS, 32'h4);
    rdchk(OFS_NEXT_SEC, 32'h78);
    wr(OFS_CTRL, 32'h0);
    wait_cyc(3);
    check_word({31'h0, ts_signal_out}, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
